// File: verilog/switch_diag_pkg.sv
// shared constants and types for the octal switch serial diagnosis block
package switch_diag_pkg;
    // ********************************************************************
    // frame layout
    // ********************************************************************
    localparam int          CHANNELS        = 8;
    localparam int          BYTE_BITS       = 8;
    localparam int          FRAME_BITS      = 16;
    localparam int          PAR_CHANNELS    = 4;
    localparam logic [4:0]  FRAME_CLOCKS    = 5'h10;
    localparam logic [4:0]  CLOCKS_SAT      = 5'h11;
    localparam logic [4:0]  CLOCKS_ZERO     = 5'h00;
    localparam logic [7:0]  CTRL_DIAG_ONLY  = 8'h00;
    localparam logic [7:0]  CTRL_ALL_ON     = 8'hff;
    localparam logic [7:0]  LATCH_RESET     = 8'h00;
    // ********************************************************************
    // two-bit diagnosis codes, first bit sent is bit 1
    // ********************************************************************
    localparam logic [1:0]  CODE_OK         = 2'h3;
    localparam logic [1:0]  CODE_LIMIT      = 2'h2;
    localparam logic [1:0]  CODE_OPEN       = 2'h1;
    localparam logic [1:0]  CODE_SHORT_GND  = 2'h0;
    localparam logic [15:0] DIAG_CLEAR      = 16'hffff;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] data;
    } frame_type;

    typedef struct packed {
        logic [CHANNELS-1:0] limit_active;
        logic [CHANNELS-1:0] open_load;
        logic [CHANNELS-1:0] short_to_ground;
    } detect_type;
endpackage

// File: verilog/octal_switch_spi_diagnosis.sv
// serial control, diagnosis capture and fault flag of an octal switch
// Operation
// - fault flag pin driven low as soon as any channel reports an error
// - a channel fault is captured into the diagnosis register at once
// - a newer error on a channel overwrites its older captured code
// - serial output stays undriven while chip select is high
// - with chip select low, diagnosis bits shift out one per clock
// - rising chip select clears captured error codes, except on channels still reporting a fault
// - two diagnosis bits per channel, sixteen bits per frame
// - channel without fault reports both bits high
// - active current limiter reports high then low
// - open load reports low then high
// - short to ground reports both bits low
// - control ff applies data; channels one to four need parallel input
// - any nonzero control byte applies the data byte
// - zero control byte leaves outputs unchanged, diagnosis still sent
// - output switching starts at chip select rising edge
// - frame is control byte first, then data byte
// - frame taken only with exactly sixteen serial clocks
// - input sampled on falling clock, output changes on rising, msb first
// - chip select falling loads diagnosis into the shift register
`timescale 1ns/1ns
module octal_switch_spi_diagnosis
    import switch_diag_pkg::*;
#(
    parameter int BUF_DEPTH = 2
)(
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    cs_n,
    input  wire logic                    sclk,
    input  wire logic                    si,
    output logic                         so_out,
    output logic                         so_oe,
    output logic                         fault_out,
    output logic                         fault_oe,
    input  wire detect_type              detect,
    input  wire logic [PAR_CHANNELS-1:0] parallel_channel_input,
    input  wire logic                    stage_ready,
    output logic [CHANNELS-1:0]          channel_on
);
    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] BUF_FULL  = CNT_W'(BUF_DEPTH);
    localparam logic [CNT_W-1:0] BUF_EMPTY = '0;
    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("BUF_DEPTH must be a power of two, at least two");
    end
    // ********************************************************************
    // pin edge detection (pins are synchronous to clk_sys)
    // ********************************************************************
    logic cs_q;
    logic sclk_q;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cs_q   <= 1'b1;
            sclk_q <= 1'b0;
        end
        else
        begin
            cs_q   <= cs_n;
            sclk_q <= sclk;
        end
    end

    assign cs_fall   = cs_q & ~cs_n;
    assign cs_rise   = ~cs_q & cs_n;
    // clock edges only count inside a frame; sclk is ignored with cs high
    assign sclk_rise = ~cs_n & ~cs_q & ~sclk_q & sclk;
    assign sclk_fall = ~cs_n & ~cs_q & sclk_q & ~sclk;
    // ********************************************************************
    // per-channel code from the detectors and diagnosis capture
    // ********************************************************************
    logic [CHANNELS-1:0][1:0] diag;
    logic [CHANNELS-1:0][1:0] new_code;
    logic [CHANNELS-1:0]      live_fault;

    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
        // limiter outranks open load, open load outranks short to ground
        always_comb
        begin
            if (detect.limit_active[ch])
                new_code[ch] = CODE_LIMIT;
            else if (detect.open_load[ch])
                new_code[ch] = CODE_OPEN;
            else if (detect.short_to_ground[ch])
                new_code[ch] = CODE_SHORT_GND;
            else
                new_code[ch] = CODE_OK;
        end
        assign live_fault[ch] = (new_code[ch] != CODE_OK);

        // a fault in the clearing cycle survives the clear
        always_ff @(posedge clk_sys)
        begin
            if (rst)
                diag[ch] <= CODE_OK;
            else if (live_fault[ch])
                diag[ch] <= new_code[ch];
            else if (cs_rise)
                diag[ch] <= CODE_OK;
        end
    end
    // ********************************************************************
    // fault flag, open drain: enable high pulls the pin low
    // ********************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            fault_out <= 1'b0;
            fault_oe  <= 1'b0;
        end
        else
        begin
            fault_out <= 1'b0;
            fault_oe  <= (|live_fault) | (diag != DIAG_CLEAR);
        end
    end
    // ********************************************************************
    // transmit shift register and serial output
    // ********************************************************************
    logic [FRAME_BITS-1:0] tx_shift;
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tx_shift <= DIAG_CLEAR;
            so_out   <= 1'b1;
            so_oe    <= 1'b0;
        end
        else
        begin
            so_oe <= ~cs_n;
            if (cs_fall)
            begin
                tx_shift <= diag;
                so_out   <= diag[CHANNELS-1][1];
            end
            else if (sclk_rise)
            begin
                tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b1};
                so_out   <= tx_shift[FRAME_BITS-2];
            end
        end
    end
    // ********************************************************************
    // receive shift register and clock count
    // ********************************************************************
    frame_type  rx_frame;
    logic [4:0] clk_count;
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rx_frame  <= '0;
            clk_count <= CLOCKS_ZERO;
        end
        else if (cs_fall)
            clk_count <= CLOCKS_ZERO;
        else if (sclk_fall)
        begin
            rx_frame <= {rx_frame[FRAME_BITS-2:0], si};
            // saturate so a long frame never wraps back to sixteen
            if (clk_count != CLOCKS_SAT)
                clk_count <= clk_count + 5'h01;
        end
    end
    // ********************************************************************
    // frame decode; pending frame waits for a free buffer slot
    // ********************************************************************
    logic      frame_ok;
    logic      pending;
    frame_type pending_frame;
    logic      buf_ready;

    assign frame_ok = cs_rise && clk_count == FRAME_CLOCKS
                      && rx_frame.ctrl != CTRL_DIAG_ONLY;

    // a frame arriving while one still waits replaces it: newest wins
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pending       <= 1'b0;
            pending_frame <= '0;
        end
        else if (frame_ok)
        begin
            pending       <= 1'b1;
            pending_frame <= rx_frame;
        end
        else if (buf_ready)
            pending <= 1'b0;
    end
    // ********************************************************************
    // two-entry buffer toward the output stage
    // ********************************************************************
    frame_type          buf_mem [BUF_DEPTH];
    logic [PTR_W-1:0]   wr_ptr;
    logic [PTR_W-1:0]   rd_ptr;
    logic [CNT_W-1:0]   buf_count;
    logic               buf_push;
    logic               buf_pop;

    assign buf_ready = (buf_count != BUF_FULL);
    assign buf_push  = pending & buf_ready;
    assign buf_pop   = (buf_count != BUF_EMPTY) & stage_ready;

    always_ff @(posedge clk_sys)
    begin
        if (buf_push)
            buf_mem[wr_ptr] <= pending_frame;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            buf_count <= BUF_EMPTY;
        end
        else
        begin
            if (buf_push)
                wr_ptr <= wr_ptr + PTR_W'(1);
            if (buf_pop)
                rd_ptr <= rd_ptr + PTR_W'(1);
            if (buf_push && !buf_pop)
                buf_count <= buf_count + CNT_W'(1);
            else if (buf_pop && !buf_push)
                buf_count <= buf_count - CNT_W'(1);
        end
    end
    // ********************************************************************
    // output latch and channel drive
    // ********************************************************************
    logic [CHANNELS-1:0] out_latch;
    logic [CHANNELS-1:0] par_mask;

    assign par_mask = {{(CHANNELS-PAR_CHANNELS){1'b1}},
                       parallel_channel_input};

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            out_latch  <= LATCH_RESET;
            channel_on <= LATCH_RESET;
        end
        else
        begin
            if (buf_pop)
                out_latch <= buf_mem[rd_ptr].data;
            channel_on <= out_latch & par_mask;
        end
    end
    // ********************************************************************
    // assertions
    // ********************************************************************
    property p_fault_flag;
        @(posedge clk_sys) disable iff (rst)
        (|live_fault) |=> fault_oe && !fault_out;
    endproperty
    a_fault_flag: assert property (p_fault_flag)
        else $error("fault flag not pulled low after channel error");
    property p_capture;
        @(posedge clk_sys) disable iff (rst)
        live_fault[0] |=> diag[0] == $past(new_code[0]);
    endproperty
    a_capture: assert property (p_capture)
        else $error("channel one fault not captured");
    property p_overwrite;
        @(posedge clk_sys) disable iff (rst)
        (live_fault[2] && diag[2] != CODE_OK
            && new_code[2] != diag[2]) |=> diag[2] == $past(new_code[2]);
    endproperty
    a_overwrite: assert property (p_overwrite)
        else $error("newer error did not replace older code");
    property p_so_hiz;
        @(posedge clk_sys) disable iff (rst)
        cs_n [*2] |-> !so_oe;
    endproperty
    a_so_hiz: assert property (p_so_hiz)
        else $error("serial output driven while deselected");
    property p_shift;
        @(posedge clk_sys) disable iff (rst)
        sclk_rise |=> so_out == $past(tx_shift[FRAME_BITS-2]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("serial output did not advance on clock rise");
    property p_clear;
        @(posedge clk_sys) disable iff (rst)
        (cs_rise && live_fault == '0) |=> diag == DIAG_CLEAR;
    endproperty
    a_clear: assert property (p_clear)
        else $error("diagnosis not cleared at chip select rise");
    property p_load;
        @(posedge clk_sys) disable iff (rst)
        cs_fall |=> tx_shift == $past(diag) && so_out == tx_shift[15];
    endproperty
    a_load: assert property (p_load)
        else $error("diagnosis not loaded at chip select fall");
    property p_accept;
        @(posedge clk_sys) disable iff (rst)
        (cs_rise && !pending && (clk_count != FRAME_CLOCKS
            || rx_frame.ctrl == CTRL_DIAG_ONLY)) |=> !pending;
    endproperty
    a_accept: assert property (p_accept)
        else $error("frame accepted with wrong count or control byte");
    property p_apply;
        @(posedge clk_sys) disable iff (rst)
        buf_pop |=> ##1 channel_on[7:4] == $past(buf_mem[rd_ptr].data[7:4], 2);
    endproperty
    a_apply: assert property (p_apply)
        else $error("upper channels did not follow data byte");

    c_accept: cover property (@(posedge clk_sys) disable iff (rst) frame_ok);
    c_diag_only: cover property (@(posedge clk_sys) disable iff (rst)
        cs_rise && clk_count == FRAME_CLOCKS
        && rx_frame.ctrl == CTRL_DIAG_ONLY);
    c_buf_full: cover property (@(posedge clk_sys) disable iff (rst)
        buf_count == BUF_FULL && pending);
endmodule // octal_switch_spi_diagnosis

// File: test/spi_host.sv
// host model that drives serial frames into the switch block
`timescale 1ns/1ns
module spi_host (
    input  wire logic clk_sys,
    output logic      cs_n,
    output logic      sclk,
    output logic      si,
    input  wire logic so_out,
    input  wire logic so_oe
);
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end
    // ****************************************************************
    // one frame of n clock pulses; sclk low at chip select edges
    // ****************************************************************
    task automatic xfer(input logic [15:0] tx, input int n,
                        output logic [15:0] rx, output logic oe_ok);
        rx    = 16'hffff;
        oe_ok = 1'b1;
        @(posedge clk_sys);
        cs_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < n; i++)
        begin
            si <= (i < 16) ? tx[15-i] : ~si;
            @(negedge clk_sys);
            if (i < 16)
                rx[15-i] = so_out;
            oe_ok = oe_ok & so_oe;
            @(posedge clk_sys);
            sclk <= 1'b1;
            repeat (3) @(posedge clk_sys);
            sclk <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
        cs_n <= 1'b1;
        // released line must not keep showing the last bit
        si   <= ~si;
        repeat (3) @(posedge clk_sys);
    endtask
endmodule // spi_host

// File: test/tb.sv
// self-checking bench for the octal switch serial diagnosis block
`timescale 1ns/1ns
module tb
    import switch_diag_pkg::*;
;
    typedef struct packed {
        detect_type  det;
        logic [7:0]  ctrl;
        logic [7:0]  data;
        logic [3:0]  par;
        logic [15:0] diag;
        logic [7:0]  on;
    } row_type;

    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        cs_n;
    logic        sclk;
    logic        si;
    logic        so_out;
    logic        so_oe;
    logic        fault_out;
    logic        fault_oe;
    detect_type  detect  = '0;
    logic [3:0]  par     = 4'hf;
    logic        stage_ready = 1'b1;
    logic [7:0]  channel_on;
    logic [15:0] rx;
    logic        oe_ok;
    int          n_fail  = 0;
    int          total_checks = 0;
    int          cycles  = 0;
    // diagnosis codes worked out per channel, ch8 pair on top
    row_type     rows [4] = '{
        '{24'h000000, 8'hff, 8'ha5, 4'hf, 16'hffff, 8'ha5},
        '{24'h800108, 8'h81, 8'h3c, 4'h5, 16'hbf3d, 8'h34},
        '{24'h020202, 8'h00, 8'hff, 4'h5, 16'hfffb, 8'h34},
        '{24'h00f001, 8'h01, 8'h0f, 4'ha, 16'h55fc, 8'h0a}};

    always #2 clk_sys = ~clk_sys;

    spi_host host_u (
        .clk_sys (clk_sys),
        .cs_n    (cs_n),
        .sclk    (sclk),
        .si      (si),
        .so_out  (so_out),
        .so_oe   (so_oe)
    );

    octal_switch_spi_diagnosis dut_u (
        .clk_sys                (clk_sys),
        .rst                    (rst),
        .cs_n                   (cs_n),
        .sclk                   (sclk),
        .si                     (si),
        .so_out                 (so_out),
        .so_oe                  (so_oe),
        .fault_out              (fault_out),
        .fault_oe               (fault_oe),
        .detect                 (detect),
        .parallel_channel_input (par),
        .stage_ready            (stage_ready),
        .channel_on             (channel_on)
    );
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask

    task automatic frame(input logic [15:0] tx, input int n);
        host_u.xfer(tx, n, rx, oe_ok);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard, far above the roughly 1900 cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            n_fail++;
            results();
        end
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        settle(1);
        chk("reset outputs", 12'h100,
            {so_oe, fault_oe, fault_out, so_out, channel_on});
        $display("test reset done");
        foreach (rows[i])
        begin
            @(posedge clk_sys);
            detect <= rows[i].det;
            par    <= rows[i].par;
            repeat (4) @(posedge clk_sys);
            frame({rows[i].ctrl, rows[i].data}, 16);
            frame({rows[i].ctrl, rows[i].data}, 16);
            settle(8);
            chk("diag", rows[i].diag, rx);
            chk("channel_on", rows[i].on, channel_on);
            chk("fault pin", {|rows[i].det, 1'b0},
                {fault_oe, fault_out});
            chk("so_oe", 2'b10, {oe_ok, so_oe});
        end
        $display("test rows done");
        @(posedge clk_sys);
        detect <= 24'h000400;
        @(posedge clk_sys);
        detect <= 24'h000004;
        @(posedge clk_sys);
        detect <= '0;
        settle(3);
        chk("fault_oe held", 1'b1, fault_oe);
        frame(16'h0000, 16);
        // codes latched in the last row stay until a fault-free clear
        chk("diag overwrite", 16'h55cc, rx);
        frame(16'h0000, 16);
        settle(2);
        chk("diag cleared", 16'hffff, rx);
        chk("fault_oe cleared", 1'b0, fault_oe);
        $display("test capture done");
        frame(16'hfff0, 15);
        frame(16'hff50, 17);
        settle(8);
        chk("short frames", 8'h0a, channel_on);
        $display("test count done");
        @(posedge clk_sys);
        par         <= 4'hf;
        stage_ready <= 1'b0;
        frame(16'hff11, 16);
        frame(16'hff22, 16);
        frame(16'hff33, 16);
        settle(6);
        chk("stalled", 8'h0f, channel_on);
        @(posedge clk_sys);
        stage_ready <= 1'b1;
        settle(10);
        chk("drained", 8'h33, channel_on);
        $display("test buffer done");
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        settle(1);
        chk("second reset", 12'h100,
            {so_oe, fault_oe, fault_out, so_out, channel_on});
        $display("test second reset done");
        results();
    end
endmodule // tb
